// file: src/qfs_sequencer.v
// quad phase fetch/execute sequencer with apb access to the pc registers
//
// Implementation choice: the APB slave port.
`include "qfs_regs.vh"

// Overview of operation
// - clock divided by four into four successive non-overlapping phases per cycle
// - program counter steps once per instruction cycle, in phase one
// - program word read during fetch cycle, captured into holding register at phase four
// - fetch and execute overlap, one instruction per cycle throughput
// - fetched word shown to decoder in phase one, executed in phases two to four
// - data operand read in phase two, destination written in phase four
// - instructions that change the program counter take two cycles, others one
// - taken branch flushes the prefetched word as a no-op while target fetches
// - rc mode drives the rate output at a quarter of the input clock
// - pc low byte is a readable writable register, zero after any reset
// - upper pc write buffer holds five bits, top three read zero, reset zero
module qfs_sequencer (
   // clock and reset
   input  wire                         clock,
   input  wire                         rst_n,
   input  wire                         master_clear_n,
   // apb slave
   input  wire                         psel,
   input  wire                         penable,
   input  wire                         pwrite,
   input  wire [`QFS_PADDR_W-1:0]      paddr,
   input  wire [`QFS_DATA_W-1:0]       pwdata,
   output wire [`QFS_DATA_W-1:0]       prdata,
   output wire                         pready,
   output wire                         pslverr,
   // phase clocks and rate output
   output wire                         phase_one,
   output wire                         phase_two,
   output wire                         phase_three,
   output wire                         phase_four,
   output wire                         instr_rate_output,
   // program memory
   output wire [`QFS_PC_W-1:0]         prog_addr,
   output wire                         prog_rd_en,
   input  wire [`QFS_INSTR_W-1:0]      prog_data,
   // data memory
   output wire [`QFS_DADDR_W-1:0]      data_addr,
   output wire                         data_rd_en,
   input  wire [`QFS_BYTE_W-1:0]       data_rd_data,
   output wire                         data_wr_en,
   output wire [`QFS_BYTE_W-1:0]       data_wr_data,
   // execute unit
   output wire [`QFS_INSTR_W-1:0]      exec_instr,
   output wire                         exec_valid,
   output wire                         exec_decode,
   output wire [`QFS_BYTE_W-1:0]       exec_operand,
   input  wire [`QFS_BANK_W-1:0]       bank_sel,
   input  wire [`QFS_BYTE_W-1:0]       alu_result,
   input  wire                         alu_write
);

   localparam [3:0] PH_ONE   = 4'h1;
   localparam [3:0] PH_TWO   = 4'h2;
   localparam [3:0] PH_THREE = 4'h4;
   localparam [3:0] PH_FOUR  = 4'h8;

   reg  [3:0]                  phase_reg;
   reg  [3:0]                  phase_next;
   reg  [`QFS_PC_W-1:0]        pc_reg;
   reg  [`QFS_PC_W-1:0]        prog_addr_reg;
   reg                         prog_rd_en_reg;
   reg  [`QFS_INSTR_W-1:0]     ir_reg;
   reg                         ir_valid_reg;
   reg  [`QFS_UPPER_W-1:0]     upper_reg;
   reg                         pc_load_reg;
   reg  [`QFS_PC_W-1:0]        pc_load_val_reg;
   reg  [`QFS_DADDR_W-1:0]     data_addr_reg;
   reg                         data_rd_en_reg;
   reg                         data_wr_en_reg;
   reg  [`QFS_BYTE_W-1:0]      data_wr_data_reg;
   reg  [`QFS_BYTE_W-1:0]      operand_reg;
   reg                         rate_reg;
   reg                         rc_mode_reg;
   reg  [`QFS_DATA_W-1:0]      prdata_reg;
   reg                         pslverr_reg;
   reg  [`QFS_DATA_W-1:0]      rd_value;
   reg                         rate_next;
   reg  [`QFS_BYTE_W-1:0]      operand_next;

   wire                        core_rst;
   wire                        apb_setup;
   wire                        apb_write;
   wire [9:0]                  apb_idx;
   wire                        sel_pcl;
   wire                        sel_upper;
   wire                        sel_ctrl;
   wire                        sel_stat;
   wire                        mapped;
   wire [`QFS_FILE_W-1:0]      file_addr;
   wire                        file_is_pcl;
   wire                        file_is_upper;
   wire                        take_jump;
   wire                        redirect;
   wire [`QFS_PC_W-1:0]        jump_target;
   wire [`QFS_PC_W-1:0]        fetch_target;
   wire                        exec_write;
   wire                        core_file;

   // master clear shares the synchronous reset path
   assign core_rst = ~rst_n | ~master_clear_n;

   // phase rotation
   always @* begin
      case (phase_reg)
         PH_ONE:   phase_next = PH_TWO;
         PH_TWO:   phase_next = PH_THREE;
         PH_THREE: phase_next = PH_FOUR;
         PH_FOUR:  phase_next = PH_ONE;
         default:  phase_next = PH_ONE;
      endcase
   end

   assign phase_one   = phase_reg[0];
   assign phase_two   = phase_reg[1];
   assign phase_three = phase_reg[2];
   assign phase_four  = phase_reg[3];

   // apb decode; slave answers with zero wait states
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign apb_idx   = paddr[`QFS_PADDR_W-1:2];
   assign sel_pcl   = (apb_idx == `QFS_IDX_PCL);
   assign sel_upper = (apb_idx == `QFS_IDX_UPPER);
   assign sel_ctrl  = (apb_idx == `QFS_IDX_CTRL);
   assign sel_stat  = (apb_idx == `QFS_IDX_STAT);
   assign mapped    = sel_pcl | sel_upper | sel_ctrl | sel_stat;
   assign pready    = 1'b1;
   assign prdata    = prdata_reg;
   assign pslverr   = pslverr_reg;

   always @* begin
      rd_value = {`QFS_DATA_W{1'b0}};
      if (sel_pcl) begin
         rd_value[`QFS_PCL_W-1:0] = pc_reg[`QFS_PCL_W-1:0];
      end else if (sel_upper) begin
         rd_value[`QFS_UPPER_W-1:0] = upper_reg;
      end else if (sel_ctrl) begin
         rd_value[`QFS_CTRL_RC_BIT] = rc_mode_reg;
      end else if (sel_stat) begin
         rd_value[`QFS_STAT_PC_LSB +: `QFS_PC_W] = pc_reg;
         rd_value[`QFS_STAT_VALID_BIT]          = ir_valid_reg;
         rd_value[`QFS_STAT_PH_LSB +: 4]        = phase_reg;
      end
   end

   // read data is latched in the setup cycle so it comes from a flop
   always @(posedge clock) begin
      if (!rst_n) begin
         prdata_reg <= {`QFS_DATA_W{1'b0}};
      end else if (apb_setup) begin
         prdata_reg <= pwrite ? {`QFS_DATA_W{1'b0}} : rd_value;
      end
   end

   // unmapped indices are refused; a write to them changes nothing
   always @(posedge clock) begin
      if (!rst_n) begin
         pslverr_reg <= 1'b0;
      end else if (apb_setup) begin
         pslverr_reg <= ~mapped;
      end
   end

   // oscillator mode survives master clear, only the bus reset clears it
   always @(posedge clock) begin
      if (!rst_n) begin
         rc_mode_reg <= `QFS_CTRL_RESET;
      end else if (apb_write & sel_ctrl) begin
         rc_mode_reg <= pwdata[`QFS_CTRL_RC_BIT];
      end
   end

   // execute-stage decode
   assign file_addr     = ir_reg[`QFS_FILE_MSB:0];
   assign file_is_pcl   = (file_addr == `QFS_FILE_PCL);
   assign file_is_upper = (file_addr == `QFS_FILE_UPPER);
   assign take_jump     = ir_valid_reg & (ir_reg[`QFS_OP_MSB:`QFS_OP_LSB] == `QFS_OP_JUMP);
   assign jump_target   = {upper_reg[`QFS_UPPER_JMP_MSB:`QFS_UPPER_JMP_LSB], ir_reg[`QFS_JUMP_MSB:0]};
   assign redirect      = take_jump | pc_load_reg;
   assign exec_write    = ir_valid_reg & alu_write;
   assign core_file     = file_is_pcl | file_is_upper;
   // a pending pc write wins over a jump in the same slot
   assign fetch_target  = pc_load_reg ? pc_load_val_reg : (take_jump ? jump_target : pc_reg);

   assign exec_decode = phase_reg[0] & ir_valid_reg;
   assign exec_instr  = ir_reg;
   assign exec_valid  = ir_valid_reg;
   assign exec_operand = operand_reg;
   assign prog_addr   = prog_addr_reg;
   assign prog_rd_en  = prog_rd_en_reg;
   assign data_addr   = data_addr_reg;
   assign data_rd_en  = data_rd_en_reg;
   assign data_wr_en  = data_wr_en_reg;
   assign data_wr_data = data_wr_data_reg;
   assign instr_rate_output = rate_reg;

   // phase ring
   always @(posedge clock) begin
      if (core_rst) begin
         phase_reg <= PH_ONE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // fetch strobe and rate output follow the next phase so they line up with it
   always @(posedge clock) begin
      if (core_rst) begin
         prog_rd_en_reg <= 1'b0;
         rate_reg       <= 1'b0;
      end else begin
         prog_rd_en_reg <= phase_next[3];
         rate_reg       <= rate_next;
      end
   end

   // high through phases three and four; a pulse only starts at phase three,
   // so a mode change never leaves a runt pulse on the pin
   always @* begin
      case (phase_next)
         PH_THREE: begin
            rate_next = rc_mode_reg;
         end
         PH_FOUR: begin
            rate_next = rate_reg;
         end
         default: begin
            rate_next = 1'b0;
         end
      endcase
   end

   // program counter and fetch address
   always @(posedge clock) begin
      if (core_rst) begin
         pc_reg        <= `QFS_RESET_VECTOR;
         prog_addr_reg <= `QFS_RESET_VECTOR;
      end else begin
         case (phase_reg)
            PH_ONE: begin
               pc_reg <= pc_reg + `QFS_PC_STEP;
            end
            PH_FOUR: begin
               prog_addr_reg <= fetch_target;
               pc_reg        <= fetch_target;
            end
            default: begin
               pc_reg <= pc_reg;
            end
         endcase
      end
   end

   // instruction holding register
   always @(posedge clock) begin
      if (core_rst) begin
         ir_reg       <= {`QFS_INSTR_W{1'b0}};
         ir_valid_reg <= 1'b0;
      end else if (phase_reg == PH_FOUR) begin
         ir_reg       <= prog_data;
         // the word just fetched is dropped when the pc is redirected
         ir_valid_reg <= ~redirect;
      end
   end

   // operand address and read strobe
   always @(posedge clock) begin
      if (core_rst) begin
         data_addr_reg  <= {`QFS_DADDR_W{1'b0}};
         data_rd_en_reg <= 1'b0;
      end else if (phase_reg == PH_ONE) begin
         data_addr_reg  <= {bank_sel, file_addr};
         data_rd_en_reg <= ir_valid_reg & ~core_file;
      end else begin
         data_rd_en_reg <= 1'b0;
      end
   end

   // core registers answer from inside, memory is not consulted
   always @* begin
      if (file_is_pcl) begin
         operand_next = pc_reg[`QFS_PCL_W-1:0];
      end else if (file_is_upper) begin
         operand_next = {{(`QFS_BYTE_W-`QFS_UPPER_W){1'b0}}, upper_reg};
      end else begin
         operand_next = data_rd_data;
      end
   end

   always @(posedge clock) begin
      if (core_rst) begin
         operand_reg <= {`QFS_BYTE_W{1'b0}};
      end else if (phase_reg == PH_TWO) begin
         operand_reg <= operand_next;
      end
   end

   // destination write, held through phase four only
   always @(posedge clock) begin
      if (core_rst) begin
         data_wr_en_reg   <= 1'b0;
         data_wr_data_reg <= {`QFS_BYTE_W{1'b0}};
      end else if (phase_reg == PH_THREE) begin
         data_wr_en_reg   <= exec_write & ~core_file;
         data_wr_data_reg <= alu_result;
      end else begin
         data_wr_en_reg   <= 1'b0;
      end
   end

   // software writes win over the data path and land at the next cycle boundary
   always @(posedge clock) begin
      if (core_rst) begin
         pc_load_reg     <= 1'b0;
         pc_load_val_reg <= `QFS_RESET_VECTOR;
      end else if (apb_write & sel_pcl) begin
         pc_load_reg     <= 1'b1;
         pc_load_val_reg <= {upper_reg, pwdata[`QFS_PCL_W-1:0]};
      end else if ((phase_reg == PH_THREE) & exec_write & file_is_pcl) begin
         pc_load_reg     <= 1'b1;
         pc_load_val_reg <= {upper_reg, alu_result};
      end else if (phase_reg == PH_FOUR) begin
         pc_load_reg     <= 1'b0;
      end
   end

   // upper bits buffer; a pc write copies it into the counter, a jump copies only its bits 4 and 3
   always @(posedge clock) begin
      if (core_rst) begin
         upper_reg <= `QFS_UPPER_RESET;
      end else if (apb_write & sel_upper) begin
         upper_reg <= pwdata[`QFS_UPPER_W-1:0];
      end else if ((phase_reg == PH_THREE) & exec_write & file_is_upper) begin
         upper_reg <= alu_result[`QFS_UPPER_W-1:0];
      end
   end

endmodule // qfs_sequencer

// file: shared/qfs_regs.vh
// register indices, field layouts and reset values of the quad phase sequencer
`ifndef QFS_REGS_VH
`define QFS_REGS_VH

// register indices; byte address is four times the index
`define QFS_IDX_PCL        10'h082
`define QFS_IDX_UPPER      10'h08a
`define QFS_IDX_CTRL       10'h090
`define QFS_IDX_STAT       10'h091

// apb geometry
`define QFS_PADDR_W        12
`define QFS_DATA_W         32

// core register fields
`define QFS_PCL_W          8
`define QFS_UPPER_W        5
`define QFS_PC_W           13
`define QFS_PCL_RESET      8'h00
`define QFS_UPPER_RESET    5'h00
`define QFS_RESET_VECTOR   13'h0000
`define QFS_PC_STEP        13'h0001

// control register: bit 0 selects resistor-capacitor oscillator mode
`define QFS_CTRL_RC_BIT    0
`define QFS_CTRL_RESET     1'b0

// status register fields
`define QFS_STAT_PC_LSB    0
`define QFS_STAT_VALID_BIT 16
`define QFS_STAT_PH_LSB    20

// instruction word layout
`define QFS_INSTR_W        14
`define QFS_OP_MSB         13
`define QFS_OP_LSB         12
`define QFS_OP_JUMP        2'b10
`define QFS_JUMP_MSB       10
`define QFS_UPPER_JMP_MSB  4
`define QFS_UPPER_JMP_LSB  3
`define QFS_FILE_MSB       6
`define QFS_FILE_W         7

// file addresses of the core registers inside data space
`define QFS_FILE_PCL       7'h02
`define QFS_FILE_UPPER     7'h0a

// data memory
`define QFS_BANK_W         2
`define QFS_DADDR_W        9
`define QFS_BYTE_W         8

`endif

// file: tb/qfs_sequencer_chk.sv
// assertion checker on the sequencer ports
`include "qfs_regs.vh"
module qfs_sequencer_chk (
   // clock and resets
   input wire logic                    clock,
   input wire logic                    rst_n,
   input wire logic                    master_clear_n,
   // phases and strobes
   input wire logic                    phase_one,
   input wire logic                    phase_two,
   input wire logic                    phase_three,
   input wire logic                    phase_four,
   input wire logic                    instr_rate_output,
   input wire logic                    prog_rd_en,
   input wire logic                    data_rd_en,
   input wire logic                    data_wr_en,
   input wire logic                    exec_valid,
   input wire logic                    exec_decode,
   // fetch address and held word
   input wire logic [`QFS_PC_W-1:0]    prog_addr,
   input wire logic [`QFS_INSTR_W-1:0] exec_instr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n || !master_clear_n);
   AST_PH_ORDER: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
      else $error("phase order broken");
   AST_ADDR_HOLD: assert property (!phase_four |=> $stable(prog_addr))
      else $error("fetch address moved inside a cycle");
   AST_FETCH_EN: assert property (prog_rd_en == phase_four)
      else $error("fetch strobe off phase four");
   AST_DECODE: assert property (exec_decode == (phase_one && exec_valid))
      else $error("decode strobe wrong");
   AST_RD_PH2: assert property (data_rd_en |-> phase_two && exec_valid)
      else $error("operand read off phase two");
   AST_WR_PH4: assert property (data_wr_en |-> phase_four && exec_valid)
      else $error("destination write off phase four");
   AST_FLUSH: assert property (phase_four && exec_valid && exec_instr[13:12] == `QFS_OP_JUMP |=> !exec_valid)
      else $error("prefetched word not flushed");
   AST_RATE: assert property ($rose(instr_rate_output) |-> phase_three ##1 instr_rate_output ##1 !instr_rate_output)
      else $error("rate output not a quarter rate");
   cover property (phase_four && exec_valid && exec_instr[13:12] == `QFS_OP_JUMP);
   cover property (data_wr_en);
   cover property ($rose(instr_rate_output));
endmodule // qfs_sequencer_chk

bind qfs_sequencer qfs_sequencer_chk u_qfs_sequencer_chk (.clock, .rst_n, .master_clear_n, .phase_one, .phase_two,
   .phase_three, .phase_four, .instr_rate_output, .prog_rd_en, .data_rd_en, .data_wr_en, .exec_valid,
   .exec_decode, .prog_addr, .exec_instr);

// file: tb/qfs_mem_model.sv
// program and data memory model facing the sequencer
`include "qfs_regs.vh"
module qfs_mem_model (
   // clock
   input  wire logic                    clock,
   // program port
   input  wire logic [`QFS_PC_W-1:0]    prog_addr,
   input  wire logic                    prog_rd_en,
   output logic      [`QFS_INSTR_W-1:0] prog_data,
   // data port
   input  wire logic [`QFS_DADDR_W-1:0] data_addr,
   input  wire logic                    data_rd_en,
   output logic      [`QFS_BYTE_W-1:0]  data_rd_data,
   input  wire logic                    data_wr_en,
   input  wire logic [`QFS_BYTE_W-1:0]  data_wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [`QFS_INSTR_W-1:0] pmem [0:8191];
   logic [`QFS_BYTE_W-1:0]  dmem [0:511];
   // unstrobed reads show the inverse, so a stray sample cannot match by luck
   assign prog_data = prog_rd_en ? pmem[prog_addr] : ~pmem[prog_addr];
   assign data_rd_data = data_rd_en ? dmem[data_addr] : ~dmem[data_addr];
   always @(posedge clock) begin
      if (data_wr_en)
         dmem[data_addr] <= data_wr_data;
   end
endmodule // qfs_mem_model

// file: tb/tb_quad_phase_fetch_execute_sequencer.sv
// self-checking testbench for the quad phase sequencer
`include "qfs_regs.vh"
module tb_quad_phase_fetch_execute_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0, rst_n = 1'b0, master_clear_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, rate_n;
   logic        pready, pslverr, err, phase_one, phase_two, phase_three, phase_four, instr_rate_output, prog_rd_en;
   logic [12:0] prog_addr;
   logic [13:0] prog_data, exec_instr, w;
   logic [8:0]  data_addr;
   logic        data_rd_en, data_wr_en, exec_valid, exec_decode, alu_write = 1'b0, alu_wexp;
   logic [7:0]  data_rd_data, data_wr_data, exec_operand, alu_result = 8'h00, alu_exp, op_exp;
   logic [1:0]  bank_sel = 2'b00, bank_exp;
   int          fail_count = 0, tests_run = 0, exp_pc = 0, upper = 0;
   bit          skip = 1'b1;
   always #10 clock = ~clock;
   qfs_sequencer u_qfs_sequencer (.clock, .rst_n, .master_clear_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .phase_one, .phase_two, .phase_three, .phase_four, .instr_rate_output,
      .prog_addr, .prog_rd_en, .prog_data, .data_addr, .data_rd_en, .data_rd_data, .data_wr_en, .data_wr_data,
      .exec_instr, .exec_valid, .exec_decode, .exec_operand, .bank_sel, .alu_result, .alu_write);
   qfs_mem_model u_mem (.clock, .prog_addr, .prog_rd_en, .prog_data, .data_addr, .data_rd_en, .data_rd_data,
      .data_wr_en, .data_wr_data);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clock) begin
      alu_result <= 8'($urandom);
      alu_write <= 1'($urandom);
      bank_sel <= 2'($urandom);
   end
   // reference pipeline: expected order of executed words
   always @(posedge clock) begin
      if (!rst_n || !master_clear_n) begin
         exp_pc = 0;
         skip = 1'b1;
      end else begin
         if (phase_one) bank_exp = bank_sel;
         if (phase_two) begin
            chk(data_rd_en, exec_valid);
            chk(data_addr, {bank_exp, exec_instr[6:0]});
            op_exp = u_mem.dmem[data_addr];
         end
         if (phase_three && exec_valid) chk(exec_operand, op_exp);
         if (phase_three) begin
            alu_exp = alu_result;
            alu_wexp = alu_write;
         end
         if (phase_four) chk(data_wr_en, exec_valid & alu_wexp);
         if (phase_four && data_wr_en) chk(data_wr_data, alu_exp);
         if (phase_one && skip) begin
            chk(exec_valid, 0);
            skip = 1'b0;
         end else if (phase_one) begin
            chk(exec_valid, 1);
            chk(exec_instr, u_mem.pmem[exp_pc]);
            skip = (exec_instr[13:12] === `QFS_OP_JUMP);
            exp_pc = skip ? {upper[4:3], exec_instr[10:0]} : (exp_pc + 1) % 8192;
         end
      end
   end
   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      test_done;
   end
   initial begin
      void'($urandom(32'hb4e3304e));
      // random words avoid jumps and the two pc file addresses
      for (int i = 0; i < 8192; i++) begin
         w = 14'($urandom);
         w[13] = w[13] & w[12];
         w[5] = 1'b1;
         u_mem.pmem[i] = w;
      end
      u_mem.pmem[5] = {2'b10, 1'b0, 11'h100};
      u_mem.pmem[13'h105] = {2'b10, 1'b0, 11'h022};
      for (int i = 0; i < 512; i++) u_mem.dmem[i] = 8'($urandom);
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      apb(1'b0, `QFS_IDX_PCL, 0);
      chk(rd, 0);
      apb(1'b0, `QFS_IDX_UPPER, 0);
      chk(rd, 0);
      apb(1'b1, 10'h3ff, 32'($urandom));
      chk(err, 1);
      $display("test registers done");
      master_clear_n <= 1'b1;
      repeat (200) @(posedge clock);
      for (int m = 1; m >= 0; m--) begin
         apb(1'b1, `QFS_IDX_CTRL, m);
         repeat (8) @(posedge clock);
         rate_n = 0;
         repeat (40) @(posedge clock) rate_n += instr_rate_output;
         chk(rate_n, 20 * m);
      end
      $display("test rate output done");
      apb(1'b1, `QFS_IDX_UPPER, 32'he3);
      apb(1'b0, `QFS_IDX_UPPER, 0);
      chk(rd, 32'h03);
      upper = 3;
      do @(posedge clock); while (phase_one !== 1'b1);
      apb(1'b1, `QFS_IDX_PCL, 32'h40);
      exp_pc = 13'h0340;
      skip = 1'b1;
      repeat (100) @(posedge clock);
      $display("test pc load done");
      master_clear_n <= 1'b0;
      repeat (3) @(posedge clock);
      chk(prog_addr, 0);
      apb(1'b0, `QFS_IDX_STAT, 0);
      chk(rd, 32'h0010_0000);
      master_clear_n <= 1'b1;
      upper = 0;
      @(posedge clock);
      apb(1'b0, `QFS_IDX_UPPER, 0);
      chk(rd, 0);
      repeat (100) @(posedge clock);
      $display("test master clear done");
      test_done;
   end
endmodule // tb_quad_phase_fetch_execute_sequencer
